// ---- verilog/dtc_pkg.sv ----
// package: register map, field layout, reset values and types of the dual timer/counter
package dtc_pkg;
   localparam int ADDR_W = 12;
   // register offsets
   localparam logic [11:0] ADDR_SYS_CFG = 12'h440;
   localparam logic [11:0] ADDR_MODE_CTL = 12'h45C;
   localparam logic [11:0] ADDR_CTL_FLAGS = 12'h410;
   localparam logic [11:0] ADDR_COUNT_LO0 = 12'h450;
   localparam logic [11:0] ADDR_COUNT_HI0 = 12'h451;
   localparam logic [11:0] ADDR_COUNT_LO1 = 12'h452;
   localparam logic [11:0] ADDR_COUNT_HI1 = 12'h453;
   localparam logic [11:0] ADDR_RELOAD_LO0 = 12'h454;
   localparam logic [11:0] ADDR_RELOAD_HI0 = 12'h455;
   localparam logic [11:0] ADDR_RELOAD_LO1 = 12'h456;
   localparam logic [11:0] ADDR_RELOAD_HI1 = 12'h457;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h458;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h459;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_PAIR2 = 2'h0;
   localparam logic [5:0] RST_PRESC = 6'h00;
   // field positions
   localparam int PRESC_LSB = 2;
   localparam int CTL_OVF1_BIT = 7;
   localparam int CTL_RUN1_BIT = 6;
   localparam int CTL_OVF0_BIT = 5;
   localparam int CTL_RUN0_BIT = 4;
   // prescaler codes and terminal counts
   localparam logic [1:0] PRESC_DIV4 = 2'h0;
   localparam logic [1:0] PRESC_DIV16 = 2'h1;
   localparam logic [1:0] PRESC_DIV64 = 2'h2;
   localparam logic [5:0] PRESC_LIM4 = 6'h03;
   localparam logic [5:0] PRESC_LIM16 = 6'h0F;
   localparam logic [5:0] PRESC_LIM64 = 6'h3F;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;

   typedef enum logic [1:0] {
      MODE_RELOAD16 = 2'h0,
      MODE_FREE16 = 2'h1,
      MODE_RELOAD8 = 2'h2,
      MODE_SPLIT8 = 2'h3
   } dtc_mode_type;

   // one nibble of the mode control register
   typedef struct packed {
      logic gate;
      logic ext_sel;
      dtc_mode_type mode;
   } dtc_tcfg_type;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } dtc_pair_type;
endpackage

// ---- verilog/dtc_timer_core.sv ----
// one 16-bit timer/counter: count bytes, reload and overflow detection
`timescale 1ns/1ps
module dtc_timer_core (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // configuration
   input wire dtc_pkg::dtc_mode_type mode_i,
   input wire dtc_pkg::dtc_pair_type reload_i,
   // count events
   input wire logic inc_lo_i,
   input wire logic inc_hi_i,
   // software write of count bytes
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic [7:0] wdata_i,
   // state
   output dtc_pkg::dtc_pair_type count_o,
   output logic ovf_o,
   output logic ovf_hi_o
);
   import dtc_pkg::*;

   dtc_pair_type count;
   dtc_pair_type next_count;

   //--------------------------------------------------
   // count next state
   //--------------------------------------------------
   always_comb begin
      next_count = count;
      ovf_o = 1'b0;
      ovf_hi_o = 1'b0;
      case (mode_i)
         MODE_RELOAD16, MODE_FREE16: begin
            if (inc_lo_i) begin
               if (count == WORD_MAX) begin
                  ovf_o = 1'b1;
                  next_count = (mode_i == MODE_RELOAD16) ? reload_i : dtc_pair_type'(16'h0000);
               end else begin
                  next_count = dtc_pair_type'(count + 16'h0001);
               end
            end
         end
         MODE_RELOAD8: begin
            if (inc_lo_i) begin
               if (count.lo == BYTE_MAX) begin
                  ovf_o = 1'b1;
                  next_count.lo = reload_i.lo;
               end else begin
                  next_count.lo = count.lo + 8'h01;
               end
            end
         end
         default: begin
            if (inc_lo_i) begin
               ovf_o = (count.lo == BYTE_MAX);
               next_count.lo = count.lo + 8'h01;
            end
            if (inc_hi_i) begin
               ovf_hi_o = (count.hi == BYTE_MAX);
               next_count.hi = count.hi + 8'h01;
            end
         end
      endcase
      if (wr_lo_i) begin
         next_count.lo = wdata_i;
      end
      if (wr_hi_i) begin
         next_count.hi = wdata_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         count <= dtc_pair_type'({RST_BYTE, RST_BYTE});
      end else begin
         count <= next_count;
      end
   end

   assign count_o = count;

   //--------------------------------------------------
   // checks
   //--------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_wrap16;
      inc_lo_i && count == WORD_MAX && !wr_lo_i && !wr_hi_i;
   endsequence

   a_reload_sixteen: assert property (
      (mode_i == MODE_RELOAD16) ##0 s_wrap16 |=> count == $past(reload_i) && !ovf_hi_o)
      else $error("reload16 overflow did not load reload value");

   a_free_wrap: assert property (
      (mode_i == MODE_FREE16) ##0 s_wrap16 |-> ovf_o ##1 count == 16'h0000)
      else $error("free16 overflow did not wrap to zero");

   a_reload_eight: assert property (
      (mode_i == MODE_RELOAD8 && inc_lo_i && count.lo == BYTE_MAX && !wr_lo_i && !wr_hi_i)
      |-> ovf_o ##1 (count.lo == $past(reload_i.lo) && $stable(count.hi)))
      else $error("reload8 overflow wrong");

   a_inc_one: assert property (
      (mode_i != MODE_RELOAD8 && mode_i != MODE_SPLIT8 && inc_lo_i && count != WORD_MAX
       && !wr_lo_i && !wr_hi_i) |=> count == $past(count) + 16'h0001)
      else $error("count did not advance by one");

   a_idle_hold: assert property (
      (!inc_lo_i && !inc_hi_i && !wr_lo_i && !wr_hi_i) |=> $stable(count))
      else $error("count moved without an event");
endmodule

// ---- verilog/dtc_top.sv ----
// top: register port, prescaler, pin sampling, overflow flags and interrupt of two timers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module dtc_top (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // register port
   input wire logic [dtc_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // pins
   input wire logic [1:0] ext_interrupt_pin_i,
   input wire logic [1:0] ext_count_pin_i,
   input wire logic [1:0] vector_ack_i,
   // flags and interrupt
   output logic [1:0] overflow_flag_o,
   output logic irq_o
);
   import dtc_pkg::*;

   logic [7:0] sys_cfg;
   logic [7:0] next_sys_cfg;
   logic [7:0] mode_ctl;
   logic [7:0] next_mode_ctl;
   logic [1:0] run_bit;
   logic [1:0] next_run_bit;
   logic [1:0] ovf_flag;
   logic [1:0] next_ovf_flag;
   dtc_pair_type reload [0:1];
   dtc_pair_type next_reload [0:1];
   logic [1:0] irq_stat;
   logic [1:0] next_irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] next_irq_mask;
   logic [7:0] next_rdata;
   logic ctl_wr;
   logic [1:0] wr_lo;
   logic [1:0] wr_hi;

   logic [1:0] presc_code;
   logic [5:0] presc_lim;
   logic [5:0] presc_cnt;
   logic [5:0] next_presc_cnt;
   logic tick;
   logic next_tick;
   logic sample_ph;
   logic next_sample_ph;
   logic [1:0] ext_samp;
   logic [1:0] next_ext_samp;
   logic [1:0] ext_fall;
   logic [1:0] next_ext_fall;

   dtc_tcfg_type cfg0;
   dtc_tcfg_type cfg1;
   dtc_pair_type count0;
   dtc_pair_type count1;
   logic t0_split;
   logic t1_hold;
   logic gate_ok0;
   logic gate_ok1;
   logic inc0_lo;
   logic inc0_hi;
   logic inc1;
   logic ovf0;
   logic ovf0_hi;
   logic ovf1;
   logic [1:0] ovf_evt;

   //--------------------------------------------------
   // register writes
   //--------------------------------------------------
   always_comb begin
      next_sys_cfg = sys_cfg;
      next_mode_ctl = mode_ctl;
      next_run_bit = run_bit;
      next_reload = reload;
      next_irq_mask = irq_mask;
      ctl_wr = 1'b0;
      wr_lo = 2'h0;
      wr_hi = 2'h0;
      if (reg_wr_i) begin
         if (reg_addr_i == ADDR_SYS_CFG) begin
            next_sys_cfg = reg_wdata_i;
         end else if (reg_addr_i == ADDR_MODE_CTL) begin
            next_mode_ctl = reg_wdata_i;
         end else if (reg_addr_i == ADDR_CTL_FLAGS) begin
            ctl_wr = 1'b1;
            next_run_bit = {reg_wdata_i[CTL_RUN1_BIT], reg_wdata_i[CTL_RUN0_BIT]};
         end else if (reg_addr_i == ADDR_COUNT_LO0) begin
            wr_lo[0] = 1'b1;
         end else if (reg_addr_i == ADDR_COUNT_HI0) begin
            wr_hi[0] = 1'b1;
         end else if (reg_addr_i == ADDR_COUNT_LO1) begin
            wr_lo[1] = 1'b1;
         end else if (reg_addr_i == ADDR_COUNT_HI1) begin
            wr_hi[1] = 1'b1;
         end else if (reg_addr_i == ADDR_RELOAD_LO0) begin
            next_reload[0].lo = reg_wdata_i;
         end else if (reg_addr_i == ADDR_RELOAD_HI0) begin
            next_reload[0].hi = reg_wdata_i;
         end else if (reg_addr_i == ADDR_RELOAD_LO1) begin
            next_reload[1].lo = reg_wdata_i;
         end else if (reg_addr_i == ADDR_RELOAD_HI1) begin
            next_reload[1].hi = reg_wdata_i;
         end else if (reg_addr_i == ADDR_IRQ_MASK) begin
            next_irq_mask = reg_wdata_i[1:0];
         end
      end
   end

   //--------------------------------------------------
   // flags and interrupt status
   //--------------------------------------------------
   always_comb begin
      next_ovf_flag = ovf_flag;
      if (ctl_wr) begin
         next_ovf_flag = {reg_wdata_i[CTL_OVF1_BIT], reg_wdata_i[CTL_OVF0_BIT]};
      end
      next_ovf_flag = next_ovf_flag & ~vector_ack_i;
      next_ovf_flag = next_ovf_flag | ovf_evt;
      next_irq_stat = irq_stat;
      if (reg_rd_i && reg_addr_i == ADDR_IRQ_STAT) begin
         next_irq_stat = 2'h0;
      end
      next_irq_stat = next_irq_stat | ovf_evt;
   end

   //--------------------------------------------------
   // read data, one cycle after the strobe
   //--------------------------------------------------
   always_comb begin
      next_rdata = RST_BYTE;
      if (reg_rd_i) begin
         if (reg_addr_i == ADDR_SYS_CFG) begin
            next_rdata = sys_cfg;
         end else if (reg_addr_i == ADDR_MODE_CTL) begin
            next_rdata = mode_ctl;
         end else if (reg_addr_i == ADDR_CTL_FLAGS) begin
            next_rdata = {ovf_flag[1], run_bit[1], ovf_flag[0], run_bit[0], 4'h0};
         end else if (reg_addr_i == ADDR_COUNT_LO0) begin
            next_rdata = count0.lo;
         end else if (reg_addr_i == ADDR_COUNT_HI0) begin
            next_rdata = count0.hi;
         end else if (reg_addr_i == ADDR_COUNT_LO1) begin
            next_rdata = count1.lo;
         end else if (reg_addr_i == ADDR_COUNT_HI1) begin
            next_rdata = count1.hi;
         end else if (reg_addr_i == ADDR_RELOAD_LO0) begin
            next_rdata = reload[0].lo;
         end else if (reg_addr_i == ADDR_RELOAD_HI0) begin
            next_rdata = reload[0].hi;
         end else if (reg_addr_i == ADDR_RELOAD_LO1) begin
            next_rdata = reload[1].lo;
         end else if (reg_addr_i == ADDR_RELOAD_HI1) begin
            next_rdata = reload[1].hi;
         end else if (reg_addr_i == ADDR_IRQ_STAT) begin
            next_rdata = {6'h00, irq_stat};
         end else if (reg_addr_i == ADDR_IRQ_MASK) begin
            next_rdata = {6'h00, irq_mask};
         end
      end
   end

   //--------------------------------------------------
   // prescaler and count pin sampling
   //--------------------------------------------------
   assign presc_code = sys_cfg[PRESC_LSB +: 2];

   always_comb begin
      case (presc_code)
         PRESC_DIV16: presc_lim = PRESC_LIM16;
         PRESC_DIV64: presc_lim = PRESC_LIM64;
         default: presc_lim = PRESC_LIM4;
      endcase
      next_tick = (presc_cnt >= presc_lim);
      next_presc_cnt = (presc_cnt >= presc_lim) ? RST_PRESC : presc_cnt + 6'h01;
      // pins looked at every second clock
      next_sample_ph = ~sample_ph;
      next_ext_samp = sample_ph ? ext_count_pin_i : ext_samp;
      next_ext_fall = sample_ph ? (ext_samp & ~ext_count_pin_i) : 2'h0;
   end

   //--------------------------------------------------
   // registers
   //--------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sys_cfg <= RST_BYTE;
         mode_ctl <= RST_BYTE;
         run_bit <= RST_PAIR2;
         ovf_flag <= RST_PAIR2;
         reload[0] <= dtc_pair_type'({RST_BYTE, RST_BYTE});
         reload[1] <= dtc_pair_type'({RST_BYTE, RST_BYTE});
         irq_stat <= RST_PAIR2;
         irq_mask <= RST_PAIR2;
         reg_rdata_o <= RST_BYTE;
         presc_cnt <= RST_PRESC;
         tick <= 1'b0;
         sample_ph <= 1'b0;
         ext_samp <= RST_PAIR2;
         ext_fall <= RST_PAIR2;
      end else begin
         sys_cfg <= next_sys_cfg;
         mode_ctl <= next_mode_ctl;
         run_bit <= next_run_bit;
         ovf_flag <= next_ovf_flag;
         reload <= next_reload;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         reg_rdata_o <= next_rdata;
         presc_cnt <= next_presc_cnt;
         tick <= next_tick;
         sample_ph <= next_sample_ph;
         ext_samp <= next_ext_samp;
         ext_fall <= next_ext_fall;
      end
   end

   //--------------------------------------------------
   // count enables
   //--------------------------------------------------
   assign cfg0 = dtc_tcfg_type'(mode_ctl[3:0]);
   assign cfg1 = dtc_tcfg_type'(mode_ctl[7:4]);
   assign t0_split = (cfg0.mode == MODE_SPLIT8);
   assign t1_hold = (cfg1.mode == MODE_SPLIT8);
   assign gate_ok0 = run_bit[0] & (~cfg0.gate | ext_interrupt_pin_i[0]);
   assign gate_ok1 = run_bit[1] & (~cfg1.gate | ext_interrupt_pin_i[1]);
   assign inc0_lo = gate_ok0 & (cfg0.ext_sel ? ext_fall[0] : tick);
   // split high byte: internal tick, timer 1 run bit
   assign inc0_hi = t0_split & run_bit[1] & tick;
   // with timer 0 split, timer 1 runs whenever it is out of its own split mode
   assign inc1 = ~t1_hold & (t0_split | gate_ok1) & (cfg1.ext_sel ? ext_fall[1] : tick);
   assign ovf_evt = {(t0_split ? ovf0_hi : ovf1), ovf0};

   dtc_timer_core u_timer0 (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .mode_i(cfg0.mode),
      .reload_i(reload[0]),
      .inc_lo_i(inc0_lo),
      .inc_hi_i(inc0_hi),
      .wr_lo_i(wr_lo[0]),
      .wr_hi_i(wr_hi[0]),
      .wdata_i(reg_wdata_i),
      .count_o(count0),
      .ovf_o(ovf0),
      .ovf_hi_o(ovf0_hi)
   );

   dtc_timer_core u_timer1 (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .mode_i(cfg1.mode),
      .reload_i(reload[1]),
      .inc_lo_i(inc1),
      .inc_hi_i(1'b0),
      .wr_lo_i(wr_lo[1]),
      .wr_hi_i(wr_hi[1]),
      .wdata_i(reg_wdata_i),
      .count_o(count1),
      .ovf_o(ovf1),
      .ovf_hi_o()
   );

   assign overflow_flag_o = ovf_flag;
   assign irq_o = |(irq_stat & irq_mask);

   //--------------------------------------------------
   // checks
   //--------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_div4_kept;
      (presc_code == PRESC_DIV4 && !reg_wr_i) [*5];
   endsequence

   a_tick_div_four: assert property (
      (tick ##0 s_div4_kept) |-> (tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3)))
      else $error("divide-by-4 tick spacing wrong");

   a_gate_block: assert property (
      (((cfg0.gate && !ext_interrupt_pin_i[0]) || !run_bit[0]) && !t0_split && !wr_lo[0]
       && !wr_hi[0]) |=> $stable(count0))
      else $error("gated timer 0 advanced");

   a_source_sel: assert property (
      (!t0_split && !wr_lo[0] && !wr_hi[0] && (cfg0.ext_sel ? !ext_fall[0] : !tick))
      |=> $stable(count0))
      else $error("timer 0 counted the wrong source");

   a_flag_set: assert property (
      ovf_evt[0] |=> ovf_flag[0] && irq_stat[0])
      else $error("overflow did not set flag");

   a_split_hold: assert property (
      t1_hold |-> !inc1 ##1 $stable(count1) || $past(wr_lo[1] || wr_hi[1]))
      else $error("timer 1 moved in its split mode");

   a_edge_sample: assert property (
      ext_fall[0] |-> !ext_samp[0] && $past(ext_samp[0]) && $past(sample_ph) ##1 !ext_fall[0])
      else $error("count pin edge not from two-clock sampling");

   a_flag_ack: assert property (
      (vector_ack_i[0] && !ovf_evt[0]) |=> !ovf_flag[0])
      else $error("vector ack did not clear flag");

   a_read_clear: assert property (
      (reg_rd_i && reg_addr_i == ADDR_IRQ_STAT && ovf_evt == 2'h0) |=> irq_stat == 2'h0)
      else $error("status read did not clear");
endmodule

// ---- tb/dtc_top_tb_top.sv ----
// testbench of the dual timer/counter top: registers, modes, prescaler, pins and interrupt
`timescale 1ns/1ps
module dtc_top_tb_top;
   import dtc_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [ADDR_W-1:0] reg_addr_i = 12'h000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [1:0] ext_interrupt_pin_i = 2'h3;
   logic [1:0] ext_count_pin_i = 2'h3;
   logic [1:0] vector_ack_i = 2'h0;
   logic [1:0] overflow_flag_o;
   logic irq_o;
   int n_errors = 0;
   int cmp_count = 0;

   dtc_top dut (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o),
      .ext_interrupt_pin_i(ext_interrupt_pin_i),
      .ext_count_pin_i(ext_count_pin_i),
      .vector_ack_i(vector_ack_i),
      .overflow_flag_o(overflow_flag_o),
      .irq_o(irq_o)
   );

   initial begin
      forever #2 mclk_i = ~mclk_i;
   end

   // ----------------------------------------
   // bus and compare helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask

   // read data sampled at the edge that ends its only valid cycle
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(posedge mclk_i);
      chk({8'h00, reg_rdata_o}, {8'h00, exp});
   endtask

   task automatic wait_flag(input int b, output int n);
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (overflow_flag_o[b] !== 1'b1 && n < 2000);
      chk({15'h0000, overflow_flag_o[b]}, 16'h0001);
   endtask

   task automatic done(input string name);
      $display("test %s done, errors so far %0d", name, n_errors);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic reset_case();
      logic [11:0] regs [7];
      regs = '{ADDR_SYS_CFG, ADDR_MODE_CTL, ADDR_CTL_FLAGS, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
         ADDR_COUNT_LO0, 12'h7FF};
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      wr(ADDR_SYS_CFG, 8'h0C);
      rd_chk(ADDR_SYS_CFG, 8'h0C);
      wr(ADDR_SYS_CFG, 8'h00);
      wr(ADDR_RELOAD_HI1, 8'h3C);
      rd_chk(ADDR_RELOAD_HI1, 8'h3C);
      wr(12'h7FF, 8'hA5);
      rd_chk(12'h7FF, 8'h00);
      done("reset");
   endtask

   // program one timer, run it to an overflow, time a second one when per > 0, stop it and read the count
   task automatic run_case(input int t, input int b, input logic [7:0] mode,
      input logic [7:0] presc, input logic [15:0] rl, input logic [15:0] start,
      input int per, input logic [15:0] fin);
      int n;
      logic [11:0] ofs;
      ofs = 12'(2 * t);
      wr(ADDR_MODE_CTL, mode);
      wr(ADDR_SYS_CFG, presc);
      wr(ADDR_RELOAD_LO0 + ofs, rl[7:0]);
      wr(ADDR_RELOAD_HI0 + ofs, rl[15:8]);
      wr(ADDR_COUNT_LO0 + ofs, start[7:0]);
      wr(ADDR_COUNT_HI0 + ofs, start[15:8]);
      wr(ADDR_CTL_FLAGS, (b == 1) ? 8'h40 : 8'h10);
      wait_flag(b, n);
      if (per > 0) begin
         vector_ack_i <= 2'(1 << b);
         @(posedge mclk_i);
         vector_ack_i <= 2'h0;
         wait_flag(b, n);
         chk(16'(n + 1), 16'(per));
      end
      wr(ADDR_CTL_FLAGS, 8'h00);
      @(posedge mclk_i);
      chk({14'h0000, overflow_flag_o}, 16'h0000);
      rd_chk(ADDR_COUNT_LO0 + ofs, fin[7:0]);
      rd_chk(ADDR_COUNT_HI0 + ofs, fin[15:8]);
   endtask

   task automatic irq_case();
      chk({15'h0000, irq_o}, 16'h0000);
      wr(ADDR_IRQ_MASK, 8'h01);
      @(posedge mclk_i);
      chk({15'h0000, irq_o}, 16'h0001);
      rd_chk(ADDR_IRQ_STAT, 8'h01);
      chk({15'h0000, irq_o}, 16'h0000);
      rd_chk(ADDR_IRQ_STAT, 8'h00);
      done("interrupt");
   endtask

   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge mclk_i);
         ext_count_pin_i <= 2'h2;
         repeat (4) @(posedge mclk_i);
         ext_count_pin_i <= 2'h3;
         repeat (4) @(posedge mclk_i);
      end
      repeat (6) @(posedge mclk_i);
   endtask

   task automatic ext_case();
      wr(ADDR_MODE_CTL, 8'h0D);
      wr(ADDR_COUNT_LO0, 8'h00);
      wr(ADDR_COUNT_HI0, 8'h00);
      ext_interrupt_pin_i <= 2'h2;
      wr(ADDR_CTL_FLAGS, 8'h10);
      pulses(3);
      rd_chk(ADDR_COUNT_LO0, 8'h00);
      ext_interrupt_pin_i <= 2'h3;
      pulses(3);
      rd_chk(ADDR_COUNT_LO0, 8'h03);
      wr(ADDR_MODE_CTL, 8'h05);
      pulses(2);
      rd_chk(ADDR_COUNT_LO0, 8'h05);
      wr(ADDR_CTL_FLAGS, 8'h00);
      done("counter pin and gating");
   endtask

   // reset again with state left behind: timer 0 low count byte, mode and interrupt must clear
   task automatic reset_again();
      srst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      rd_chk(ADDR_COUNT_LO0, 8'h00);
      rd_chk(ADDR_MODE_CTL, 8'h00);
      chk({15'h0000, irq_o}, 16'h0000);
      chk({14'h0000, overflow_flag_o}, 16'h0000);
      done("reset in mid-run");
   endtask

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      reset_case();
      run_case(0, 0, 8'h00, 8'h00, 16'hFFFC, 16'hFFFE, 16, 16'hFFFC);
      done("reload16 divide-by-4");
      irq_case();
      run_case(1, 1, 8'h20, 8'h04, 16'h77FD, 16'h5AFE, 48, 16'h5AFD);
      done("reload8 divide-by-16");
      run_case(0, 0, 8'h02, 8'h08, 16'h00FF, 16'h12FF, 64, 16'h12FF);
      done("reload8 divide-by-64");
      run_case(0, 0, 8'h01, 8'h00, 16'h0000, 16'hFFFE, 0, 16'h0000);
      done("free16");
      run_case(0, 1, 8'h33, 8'h00, 16'h0000, 16'hFF00, 0, 16'h0000);
      rd_chk(ADDR_COUNT_LO1, 8'hFD);
      done("split");
      ext_case();
      reset_again();
      final_report();
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      chk(16'h0000, 16'h0001);
      final_report();
   end
endmodule
